// [pmr_device.sv]
// LED device end: mode register, sleep, clock select and restart logic.
// Assumes link requests are one-cycle pulses synchronous to sys_clk.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pmr_device (
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  pmr_link.dev        lk,
  output logic [15:0] led_out,
  output logic        pwm_halted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        rst;
  logic        restart, ext_sel, autostep, sleep, group_call_enable;
  logic [2:0]  alt_en;
  logic [4:0]  m2;
  logic [7:0]  prescale, ptr, rel, pre_cnt;
  logic [7:0]  shadow [64];
  logic [7:0]  live [64];
  logic [15:0] osc_cnt;
  logic        osc_ok, osc_div, ext_prev, drain, dirty;
  logic        commit_all, commit_one;
  logic [3:0]  seen_ch, seen, next_seen;
  logic [11:0] pwm_cnt;
  logic        take, do_wr, do_rd, is_led, is_all, update_on_ack;
  logic        run, step, cnt_adv, wrap, clr_restart, set_restart;
  logic [15:0] next_led;

  // Software reset returns every register to its power-on value
  assign rst = !nrst || lk.swrst;
  assign update_on_ack = m2[pmr_pkg::OCH_BIT];
  assign rel = ptr - pmr_pkg::LED_BASE;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= pmr_pkg::LED_LAST) || (a >= pmr_pkg::ALL_BASE);
  endfunction

  function automatic logic claim(input pmr_pkg::pmr_call_t c);
    unique case (c)
      pmr_pkg::CALL_OWN:   claim = 1'b1;
      pmr_pkg::CALL_ALT1:  claim = alt_en[2];
      pmr_pkg::CALL_ALT2:  claim = alt_en[1];
      pmr_pkg::CALL_ALT3:  claim = alt_en[0];
      pmr_pkg::CALL_GROUP: claim = group_call_enable;
      default:             claim = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] step_ptr(input logic [7:0] a);
    if (a == pmr_pkg::LED_LAST || a >= pmr_pkg::PRESCALE_ADDR)
      step_ptr = pmr_pkg::PRIMARY_MODE_CONTROL_ADDR;
    else
      step_ptr = a + 8'h01;
  endfunction

  function automatic logic any_active();
    any_active = 1'b0;
    for (int c = 0; c < 16; c++)
      if (!live[4*c+3][pmr_pkg::FULL_BIT])
        any_active = 1'b1;
  endfunction

  assign is_led = (ptr >= pmr_pkg::LED_BASE) && (ptr <= pmr_pkg::LED_LAST);
  assign is_all = (ptr >= pmr_pkg::ALL_BASE) && (ptr <= pmr_pkg::ALL_OFF_H);
  assign take   = lk.req && claim(lk.call) && !lk.ptr_set && addr_ok(ptr);
  assign do_wr  = take && lk.wr;
  assign do_rd  = take && !lk.wr;

  // ----------------------------------------------------------------
  // Link answers and pointer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      lk.ack     <= 1'b0;
      lk.nak     <= 1'b0;
      lk.claimed <= 1'b0;
      ptr        <= pmr_pkg::PRIMARY_MODE_CONTROL_ADDR;
    end
    else
    begin
      lk.ack     <= lk.req;
      lk.claimed <= claim(lk.call);
      lk.nak     <= lk.req && (!claim(lk.call) ||
                    (lk.ptr_set ? !addr_ok(lk.wdata) : !addr_ok(ptr)));
      if (lk.req && lk.ptr_set && claim(lk.call) && addr_ok(lk.wdata))
        ptr <= lk.wdata;
      else if (take && autostep)
        ptr <= step_ptr(ptr);
    end

  always_ff @(posedge sys_clk)
    if (rst)
      lk.rdata <= 8'h00;
    else if (do_rd)
    begin
      if (ptr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR)
        lk.rdata <= {restart, ext_sel, autostep, sleep, alt_en,
                     group_call_enable};
      else if (ptr == pmr_pkg::SECONDARY_OUTPUT_CONTROL_ADDR)
        lk.rdata <= {3'h0, m2};
      else if (is_led)
        lk.rdata <= shadow[rel[5:0]];
      else if (ptr == pmr_pkg::PRESCALE_ADDR)
        lk.rdata <= prescale;
      else
        lk.rdata <= 8'h00;
    end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  assign clr_restart = (do_wr && ptr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR &&
                        lk.wdata[pmr_pkg::RESTART_BIT]) ||
                       commit_all || commit_one;
  // Only channels still running at the end of the cycle arm restart
  assign set_restart = wrap && drain && any_active();

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      {restart, ext_sel, autostep, sleep} <= pmr_pkg::PRIMARY_MODE_CONTROL_RST[7:4];
      {alt_en, group_call_enable}         <= pmr_pkg::PRIMARY_MODE_CONTROL_RST[3:0];
      m2       <= pmr_pkg::SECONDARY_OUTPUT_CONTROL_RST;
      prescale <= pmr_pkg::PRESCALE_RST;
    end
    else
    begin
      if (set_restart)
        restart <= 1'b1;
      else if (clr_restart)
        restart <= 1'b0;
      if (do_wr && ptr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR)
      begin
        // Sticky: a written zero never clears the clock select
        ext_sel  <= ext_sel | lk.wdata[pmr_pkg::EXT_CLOCK_SELECT_BIT];
        autostep <= lk.wdata[pmr_pkg::AUTOSTEP_BIT];
        sleep    <= lk.wdata[pmr_pkg::SLEEP_BIT];
        alt_en   <= lk.wdata[3:1];
        group_call_enable <= lk.wdata[0];
      end
      if (do_wr && ptr == pmr_pkg::SECONDARY_OUTPUT_CONTROL_ADDR)
        m2 <= lk.wdata[4:0];
      if (do_wr && ptr == pmr_pkg::PRESCALE_ADDR && sleep)
        prescale <= lk.wdata;
    end

  // ----------------------------------------------------------------
  // Channel registers and commit
  // ----------------------------------------------------------------
  always_comb
  begin
    next_seen = (rel[5:2] == seen_ch) ? seen : 4'h0;
    next_seen[rel[1:0]] = 1'b1;
  end

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      for (int i = 0; i < 64; i++)
        shadow[i] <= (i % 4 == 3) ? pmr_pkg::OFFH_RST : 8'h00;
      dirty      <= 1'b0;
      commit_all <= 1'b0;
      commit_one <= 1'b0;
      seen       <= 4'h0;
      seen_ch    <= 4'h0;
    end
    else
    begin
      commit_all <= 1'b0;
      commit_one <= 1'b0;
      if (do_wr && is_led)
      begin
        shadow[rel[5:0]] <= rel[0] ? (lk.wdata & pmr_pkg::HIGH_MASK)
                                   : lk.wdata;
        dirty <= 1'b1;
        if (update_on_ack)
        begin
          seen_ch    <= rel[5:2];
          seen       <= (&next_seen) ? 4'h0 : next_seen;
          commit_one <= &next_seen;
        end
      end
      else if (do_wr && is_all)
      begin
        // Broadcast bytes land in every channel; reads return zero
        for (int c = 0; c < 16; c++)
          // Byte within the channel: 0xfa..0xfd map to bytes 0..3
          shadow[4*c + int'(2'(ptr[1:0] - 2'h2))] <=
            ptr[0] ? (lk.wdata & pmr_pkg::HIGH_MASK) : lk.wdata;
        dirty      <= 1'b1;
        commit_all <= update_on_ack;
      end
      else if (lk.stop && dirty && !update_on_ack)
      begin
        commit_all <= 1'b1;
        dirty      <= 1'b0;
      end
    end

  // Live copy drives the comparators; held whatever the clock does
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      for (int i = 0; i < 64; i++)
        live[i] <= (i % 4 == 3) ? pmr_pkg::OFFH_RST : 8'h00;
    end
    else if (commit_all)
    begin
      for (int i = 0; i < 64; i++)
        live[i] <= shadow[i];
    end
    else if (commit_one)
    begin
      for (int b = 0; b < 4; b++)
        live[{seen_ch, 2'(b)}] <= shadow[{seen_ch, 2'(b)}];
    end

  // ----------------------------------------------------------------
  // Clock source, oscillator start-up and sleep drain
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      osc_cnt <= 16'h0000;
      osc_ok  <= 1'b0;
    end
    else if (sleep && !drain)
    begin
      osc_cnt <= 16'h0000;
      osc_ok  <= 1'b0;
    end
    else if (!osc_ok)
    begin
      osc_cnt <= osc_cnt + 16'h0001;
      osc_ok  <= (osc_cnt == 16'(pmr_pkg::OSC_START_CYC - 1));
    end

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      osc_div  <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      osc_div  <= !osc_div;
      ext_prev <= lk.ext_clk;
    end

  // External clock runs at once; internal waits for start-up
  assign run  = (ext_sel || osc_ok) && (!sleep || drain) &&
                !restart;
  assign step = run && (ext_sel ? (lk.ext_clk && !ext_prev)
                                : osc_div);
  assign cnt_adv = step && (pre_cnt == prescale);
  assign wrap    = cnt_adv && (pwm_cnt == pmr_pkg::CNT_LAST);

  always_ff @(posedge sys_clk)
    if (rst)
      drain <= 1'b0;
    else if (wrap)
      drain <= 1'b0;
    else if (do_wr && ptr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR && !sleep && run &&
             lk.wdata[pmr_pkg::SLEEP_BIT])
      drain <= 1'b1;

  // ----------------------------------------------------------------
  // PWM counter and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      pre_cnt <= 8'h00;
      pwm_cnt <= 12'h000;
    end
    else if (clr_restart && restart)
    begin
      pre_cnt <= 8'h00;
      pwm_cnt <= 12'h000;
    end
    else if (step)
    begin
      pre_cnt <= cnt_adv ? 8'h00 : pre_cnt + 8'h01;
      if (cnt_adv)
        pwm_cnt <= pwm_cnt + 12'h001;
    end

  always_comb
  begin
    next_led = led_out;
    for (int c = 0; c < 16; c++)
      if (live[4*c+3][pmr_pkg::FULL_BIT])
        next_led[c] = 1'b0;
      else if (live[4*c+1][pmr_pkg::FULL_BIT])
        next_led[c] = 1'b1;
      else if (pwm_cnt == {live[4*c+1][3:0], live[4*c]})
        next_led[c] = 1'b1;
      else if (pwm_cnt == {live[4*c+3][3:0], live[4*c+2]})
        next_led[c] = 1'b0;
  end

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      led_out    <= 16'h0000;
      pwm_halted <= 1'b1;
    end
    else
    begin
      pwm_halted <= !run;
      // Outputs only move on a counter step, never while asleep except during the drain to the cycle end
      if (cnt_adv)
        led_out <= next_led;
    end

endmodule

// [pmr_host.sv]
// Controller end: takes orders over Avalon-MM, drives the device link.
// Assumes an Avalon master that holds requests through waitrequest.
`timescale 1ns/10ps
module pmr_host (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  pmr_link.host            lk
);

  typedef enum {H_IDLE, H_PTR, H_PTR_W, H_GUARD, H_DATA, H_DATA_W,
                H_STOP} pmr_hstate_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pmr_hstate_t        st;
  pmr_pkg::pmr_call_t call_sel;
  logic [7:0]  tgt, data, cur, op_addr, rd_val;
  logic        op_wr, pre, nak, ext_on, known_sleep, guard_ok;
  logic [15:0] guard_cnt;
  logic        wtake, go, need_guard;

  assign wtake = avs_write && !avs_waitrequest;
  assign go    = wtake && avs_address == pmr_pkg::H_CMD && st == H_IDLE &&
                 (avs_writedata[pmr_pkg::CMD_WRITE] ||
                  avs_writedata[pmr_pkg::CMD_READ] ||
                  avs_writedata[pmr_pkg::CMD_SHUT]);
  // Restart write must wait out the oscillator start-up
  assign need_guard = op_wr && op_addr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR &&
                      cur[pmr_pkg::RESTART_BIT] && !guard_ok;

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        unique case (avs_address)
          pmr_pkg::H_TARGET: avs_readdata <= {21'h0, call_sel, tgt};
          pmr_pkg::H_DATA:   avs_readdata <= {24'h0, data};
          pmr_pkg::H_CMD:    avs_readdata <= {27'h0, ext_on, 4'h0};
          pmr_pkg::H_STATUS: avs_readdata <= {20'h0, lk.claimed, guard_ok,
                                              st != H_IDLE, nak, rd_val};
        endcase
    end

  always_ff @(posedge sys_clk)
    if (!nrst)
    begin
      tgt      <= pmr_pkg::PRIMARY_MODE_CONTROL_ADDR;
      data     <= 8'h00;
      call_sel <= pmr_pkg::CALL_OWN;
      ext_on   <= 1'b0;
    end
    else if (wtake)
    begin
      if (avs_address == pmr_pkg::H_TARGET)
      begin
        tgt      <= avs_writedata[7:0];
        call_sel <= pmr_pkg::pmr_call_t'(avs_writedata[10:8]);
      end
      if (avs_address == pmr_pkg::H_DATA)
        data <= avs_writedata[7:0];
      if (avs_address == pmr_pkg::H_CMD)
        ext_on <= avs_writedata[pmr_pkg::CMD_EXTON];
    end

  // ----------------------------------------------------------------
  // Wake guard and external clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (!nrst || known_sleep)
    begin
      guard_cnt <= 16'h0000;
      guard_ok  <= 1'b0;
    end
    else if (!guard_ok)
    begin
      guard_cnt <= guard_cnt + 16'h0001;
      guard_ok  <= (guard_cnt == 16'(pmr_pkg::GUARD_CYC - 1));
    end

  // External clock at half the system rate, run on request
  always_ff @(posedge sys_clk)
    if (!nrst)
      lk.ext_clk <= 1'b0;
    else
      lk.ext_clk <= ext_on && !lk.ext_clk;

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (!nrst)
    begin
      st          <= H_IDLE;
      lk.req      <= 1'b0;
      lk.wr       <= 1'b0;
      lk.ptr_set  <= 1'b0;
      lk.wdata    <= 8'h00;
      lk.stop     <= 1'b0;
      lk.swrst    <= 1'b0;
      lk.call     <= pmr_pkg::CALL_OWN;
      op_wr       <= 1'b0;
      op_addr     <= 8'h00;
      cur         <= 8'h00;
      pre         <= 1'b0;
      nak         <= 1'b0;
      rd_val      <= 8'h00;
      known_sleep <= 1'b1;
    end
    else
    begin
      lk.req   <= 1'b0;
      lk.stop  <= 1'b0;
      lk.swrst <= 1'b0;
      unique case (st)
        H_IDLE:
          if (go)
          begin
            lk.call <= call_sel;
            nak     <= 1'b0;
            if (avs_writedata[pmr_pkg::CMD_SHUT])
            begin
              op_wr   <= 1'b1;
              op_addr <= pmr_pkg::ALL_OFF_H;
              cur     <= pmr_pkg::SHUTDOWN_VAL;
              pre     <= 1'b0;
            end
            else
            begin
              op_wr   <= avs_writedata[pmr_pkg::CMD_WRITE];
              op_addr <= tgt;
              // Clock switch only while asleep; when awake, write first with the clock select bit cleared but the sleep bit as given
              pre <= avs_writedata[pmr_pkg::CMD_WRITE] &&
                     tgt == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR && !known_sleep &&
                     data[pmr_pkg::EXT_CLOCK_SELECT_BIT];
              cur <= (tgt == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR && !known_sleep &&
                      data[pmr_pkg::EXT_CLOCK_SELECT_BIT])
                     ? (data & 8'hbf) : data;
            end
            st <= H_PTR;
          end
          else if (wtake && avs_address == pmr_pkg::H_CMD)
          begin
            lk.stop  <= avs_writedata[pmr_pkg::CMD_STOP];
            lk.swrst <= avs_writedata[pmr_pkg::CMD_SWRST];
            if (avs_writedata[pmr_pkg::CMD_SWRST])
              known_sleep <= 1'b1;
          end
        H_PTR:
        begin
          lk.req     <= 1'b1;
          lk.ptr_set <= 1'b1;
          lk.wdata   <= op_addr;
          st         <= H_PTR_W;
        end
        H_PTR_W:
          if (lk.ack)
          begin
            nak <= lk.nak;
            st  <= lk.nak ? H_STOP : H_GUARD;
          end
        H_GUARD:
          if (!need_guard)
            st <= H_DATA;
        H_DATA:
        begin
          lk.req     <= 1'b1;
          lk.ptr_set <= 1'b0;
          lk.wr      <= op_wr;
          lk.wdata   <= cur;
          st         <= H_DATA_W;
        end
        H_DATA_W:
          if (lk.ack)
          begin
            nak <= lk.nak;
            if (!op_wr)
              rd_val <= lk.rdata;
            if (op_wr && op_addr == pmr_pkg::PRIMARY_MODE_CONTROL_ADDR && !lk.nak)
              known_sleep <= cur[pmr_pkg::SLEEP_BIT];
            st <= H_STOP;
          end
        H_STOP:
        begin
          lk.stop <= 1'b1;
          if (pre && !nak)
          begin
            pre <= 1'b0;
            cur <= data;
            st  <= H_PTR;
          end
          else
            st <= H_IDLE;
        end
      endcase
    end

endmodule

// [pmr_link.sv]
// Register link between the controller and the LED device.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/10ps
interface pmr_link;
  logic                req;
  logic                wr;
  logic                ptr_set;
  logic [7:0]          wdata;
  logic                stop;
  logic                swrst;
  pmr_pkg::pmr_call_t  call;
  logic                ext_clk;
  logic                ack;
  logic                nak;
  logic [7:0]          rdata;
  logic                claimed;

  modport dev (
    input  req, wr, ptr_set, wdata, stop, swrst, call, ext_clk,
    output ack, nak, rdata, claimed
  );
  modport host (
    output req, wr, ptr_set, wdata, stop, swrst, call, ext_clk,
    input  ack, nak, rdata, claimed
  );
endinterface

// [pmr_pkg.sv]
// Constants and types shared by both ends of the mode and restart link.
// Assumes a single 50 MHz system clock on both ends.
package pmr_pkg;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIMARY_MODE_CONTROL_ADDR    = 8'h00;
  localparam logic [7:0] SECONDARY_OUTPUT_CONTROL_ADDR    = 8'h01;
  localparam logic [7:0] LED_BASE      = 8'h06;
  localparam logic [7:0] LED_LAST      = 8'h45;
  localparam logic [7:0] ALL_BASE      = 8'hfa;
  localparam logic [7:0] ALL_OFF_H     = 8'hfd;
  localparam logic [7:0] PRESCALE_ADDR = 8'hfe;
  localparam logic [7:0] TEST_ADDR     = 8'hff;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RESTART_BIT  = 7;
  localparam int EXT_CLOCK_SELECT_BIT   = 6;
  localparam int AUTOSTEP_BIT = 5;
  localparam int SLEEP_BIT    = 4;
  localparam int OCH_BIT      = 3;
  localparam int FULL_BIT     = 4;
  localparam logic [7:0] PRIMARY_MODE_CONTROL_RST    = 8'h11;
  localparam logic [4:0] SECONDARY_OUTPUT_CONTROL_RST    = 5'h04;
  localparam logic [7:0] PRESCALE_RST = 8'h1e;
  localparam logic [7:0] OFFH_RST     = 8'h10;
  localparam logic [7:0] HIGH_MASK    = 8'h1f;
  localparam logic [7:0] SHUTDOWN_VAL = 8'h10;
  localparam logic [11:0] CNT_LAST    = 12'hfff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int OSC_START_US = 500;
  localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam int GUARD_US     = 500;
  localparam int GUARD_CYC    = GUARD_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Host register words (Avalon word index)
  // ----------------------------------------------------------------
  localparam logic [1:0] H_TARGET = 2'h0;
  localparam logic [1:0] H_DATA   = 2'h1;
  localparam logic [1:0] H_CMD    = 2'h2;
  localparam logic [1:0] H_STATUS = 2'h3;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ  = 1;
  localparam int CMD_STOP  = 2;
  localparam int CMD_SWRST = 3;
  localparam int CMD_EXTON = 4;
  localparam int CMD_SHUT  = 5;

  typedef enum logic [2:0] {
    CALL_OWN,
    CALL_ALT1,
    CALL_ALT2,
    CALL_ALT3,
    CALL_GROUP
  } pmr_call_t;

endpackage

// [pmr_properties.sv]
// Checker for the register link between host and device ends.
// Assumes one shared sys_clk and a synchronous active-low reset.
`timescale 1ns/10ps
module pmr_properties (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       req,
  input wire logic       stop,
  input wire logic       swrst,
  input wire logic       ack,
  input wire logic       nak,
  input wire logic [7:0] rdata
);
  // ------------------------------------------------------------
  // Link handshake
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_ack_next; req |=> ack; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack after request");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_nak_ack; nak |-> ack; endproperty
  a_nak_ack: assert property (p_nak_ack)
    else $error("nak outside ack");
  // Read data must hold between reads
  property p_rd_hold; $changed(rdata) |-> ack || $past(swrst); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without ack");
  property p_req_pulse; req |=> !req; endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  property p_stop_pulse; stop |=> !stop ##1 !stop; endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop pulse too long");
  property p_rst_pulse; swrst |=> !swrst; endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too long");
  property p_rst_quiet; swrst |=> !ack && !nak; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("answer during software reset");
  c_ok: cover property (ack && !nak);
  c_nak: cover property (nak);
  c_rst: cover property (swrst);
endmodule

// [testbench.sv]
// Bench: host and device joined by the link, driven over Avalon.
// Assumes package timing as shipped; the run is about 58k cycles.
`timescale 1ns/10ps
module testbench;
  logic        sys_clk = 0;
  logic        nrst = 0;
  logic [1:0]  avs_address = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] led_out;
  logic        pwm_halted;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [31:0] got;
  logic [31:0] e;
  logic [31:0] m;
  logic [15:0] lfsr = 16'd11787;
  logic [7:0]  v;
  logic [5:0]  ext = 0;
  int          k;
  int          fail_count = 0;
  int          checks = 0;
  pmr_link lk ();
  pmr_host i_pmr_host (.sys_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .lk);
  pmr_device i_pmr_device (.sys_clk, .nrst, .lk, .led_out, .pwm_halted);
  pmr_properties i_pmr_properties (.sys_clk, .nrst, .req(lk.req),
    .stop(lk.stop), .swrst(lk.swrst), .ack(lk.ack), .nak(lk.nak),
    .rdata(lk.rdata));
  always #10 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // Bus tasks and scoreboard
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic av(input logic w, input logic [1:0] a,
                    input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    got = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  // Status polls are noted with an empty mask: they score nothing
  task automatic op(input logic [10:0] t, input logic [7:0] d,
                    input logic [5:0] c);
    av(1, pmr_pkg::H_TARGET, {21'h0, t});
    av(1, pmr_pkg::H_DATA, {24'h0, d});
    av(1, pmr_pkg::H_CMD, {26'h0, c | ext});
    do
    begin
      eq.push_back(0);
      mq.push_back(0);
      av(0, pmr_pkg::H_STATUS, 0);
    end while (got[9] !== 1'b0);
  endtask
  task automatic rdm(input logic [10:0] t, input logic [8:0] x,
                     input logic [8:0] y);
    op(t, 8'h00, 6'h02);
    eq.push_back({23'h0, x});
    mq.push_back({23'h0, y});
    av(0, pmr_pkg::H_STATUS, 0);
  endtask
  always @(posedge sys_clk)
    if (avs_read && avs_waitrequest === 1'b0 && eq.size() > 0)
    begin
      e = eq.pop_front();
      m = mq.pop_front();
      if (m != 0)
        chk(avs_readdata & m, e);
    end
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #(20 * 95000);
    fail_count++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    chk({led_out, 15'h0, pwm_halted}, 32'h1);
    rdm(11'h000, 9'h011, 9'h1ff);
    rdm(11'h100, 9'h100, 9'h100);
    rdm(11'h400, 9'h000, 9'h100);
    op(11'h0fe, 8'h03, 6'h01);
    ext = 6'h10;
    op(11'h000, 8'h51, 6'h01);
    op(11'h000, 8'h2f, 6'h01);
    rdm(11'h100, 9'h06f, 9'h1ff);
    op(11'h0fe, 8'h55, 6'h01);
    rdm(11'h0fe, 9'h003, 9'h1ff);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      v = i[0] ? (lfsr[7:0] & 8'h0f) : lfsr[7:0];
      op(11'h006 + 11'(i), v, 6'h01);
    end
    op(11'h000, 8'h3f, 6'h01);
    k = 0;
    do
    begin
      rdm(11'h000, 9'h000, 9'h000);
      k++;
    end while (got[7] !== 1'b1 && k < 3000);
    rdm(11'h000, 9'h0ff, 9'h1ff);
    chk({31'h0, pwm_halted}, 32'h1);
    rdm(11'h009, {1'b0, v}, 9'h1ff);
    op(11'h000, 8'h6f, 6'h01);
    rdm(11'h000, 9'h0ef, 9'h1ff);
    op(11'h000, 8'hef, 6'h01);
    rdm(11'h000, 9'h06f, 9'h1ff);
    chk({31'h0, pwm_halted}, 32'h0);
    ext = 0;
    op(11'h000, 8'h00, 6'h08);
    rdm(11'h000, 9'h011, 9'h1ff);
    op(11'h009, 8'h00, 6'h01);
    op(11'h000, 8'h00, 6'h20);
    rdm(11'h009, 9'h010, 9'h1ff);
    report_and_stop();
  end
endmodule
